/* File: wdog_pkg.sv */
package wdog_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_SECOND_CFG  = 16'hA0D8;
  localparam logic [15:0] IDX_SECOND_TOUT_LOW  = 16'hA0D9;
  localparam logic [15:0] IDX_SECOND_TOUT_HIGH = 16'hA0DA;
  localparam logic [15:0] IDX_THIRD_CFG   = 16'hA0DB;
  localparam logic [15:0] IDX_THIRD_TOUT_LOW   = 16'hA0DC;
  localparam logic [15:0] IDX_THIRD_TOUT_HIGH  = 16'hA0DD;
  localparam logic [15:0] IDX_ACCESS_LOCK = 16'hA0DE;

  localparam logic [31:0] A_SECOND_CFG = {14'h0000, IDX_SECOND_CFG, 2'b00};
  localparam logic [31:0] A_SECOND_TL  = {14'h0000, IDX_SECOND_TOUT_LOW, 2'b00};
  localparam logic [31:0] A_SECOND_TH  = {14'h0000, IDX_SECOND_TOUT_HIGH, 2'b00};
  localparam logic [31:0] A_THIRD_CFG  = {14'h0000, IDX_THIRD_CFG, 2'b00};
  localparam logic [31:0] A_THIRD_TL   = {14'h0000, IDX_THIRD_TOUT_LOW, 2'b00};
  localparam logic [31:0] A_THIRD_TH   = {14'h0000, IDX_THIRD_TOUT_HIGH, 2'b00};
  localparam logic [31:0] A_LOCK       = {14'h0000, IDX_ACCESS_LOCK, 2'b00};

  // field positions in the configuration bytes
  localparam int CLR_BIT   = 7;
  localparam int REN_BIT   = 6;
  localparam int RF2_BIT   = 5;
  localparam int IEN_BIT   = 4;
  localparam int IF_BIT    = 0;
  localparam int RF3_BIT   = 0;

  localparam logic [7:0]  RST_SECOND_CFG = 8'hA7;
  localparam logic [7:0]  RST_THIRD_CFG  = 8'hD1;
  localparam logic [15:0] RST_TIMEOUT    = 16'h0FFF;

  // unlock sequence for the timed-access lock
  localparam logic [7:0] LOCK_KEY1 = 8'hAA;
  localparam logic [7:0] LOCK_KEY2 = 8'h55;

  // slow-oscillator divider masks: 2^8, 2^12 .. 2^15 edges per tick
  localparam logic [14:0] MASK_DIV8  = 15'h00FF;
  localparam logic [14:0] MASK_DIV12 = 15'h0FFF;
  localparam logic [14:0] MASK_DIV13 = 15'h1FFF;
  localparam logic [14:0] MASK_DIV14 = 15'h3FFF;
  localparam logic [14:0] MASK_DIV15 = 15'h7FFF;
  localparam logic [1:0]  THIRD_DIV_LAST = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic       reset_en;
    logic       reset_flag;
    logic       irq_en;
    logic [2:0] scale;
    logic       irq_flag;
  } second_cfg_t;

  typedef struct packed {
    logic [2:0] halt_code;
    logic       reset_flag;
  } third_cfg_t;

  typedef enum logic [2:0] {
    LK_LOCKED = 3'b001,
    LK_ARMED  = 3'b010,
    LK_OPEN   = 3'b100
  } lock_state_t;

  function automatic logic [14:0] scale_mask(input logic [2:0] sel);
    case (sel)
      3'h4:    scale_mask = MASK_DIV12;
      3'h5:    scale_mask = MASK_DIV13;
      3'h6:    scale_mask = MASK_DIV14;
      3'h7:    scale_mask = MASK_DIV15;
      default: scale_mask = MASK_DIV8;
    endcase
  endfunction : scale_mask

endpackage : wdog_pkg

/* File: pin_sync3.sv */
`timescale 1ns/1ps
module pin_sync3 (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  input  wire logic i_pin,
  output logic      o_level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // a change counts only once stages two and three agree
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
      o_level <= 1'b0;
    end else if (i_ce) begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        o_level <= s3_ff;
      end
    end
  end
endmodule : pin_sync3

/* File: wd_counter.sv */
`timescale 1ns/1ps
module wd_counter (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  input  wire logic        i_tick,
  input  wire logic        i_clear,
  input  wire logic [15:0] i_timeout,
  output logic [15:0]      o_count,
  output logic             o_expire
);
  logic [15:0] count_ff;

  assign o_count  = count_ff;
  assign o_expire = i_tick && (count_ff == i_timeout);

  // clear beats a tick in the same cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_ff <= 16'h0000;
    end else if (i_ce) begin
      if (i_clear || o_expire) begin
        count_ff <= 16'h0000;
      end else if (i_tick) begin
        count_ff <= count_ff + 16'h0001;
      end
    end
  end
endmodule : wd_counter

/* File: low_speed_dual_watchdog.sv */
`timescale 1ns/1ps
// Overview of operation
// R1: writing one to second_count_clear zeroes the second count; reads as zero
// R2: second timeout with second_reset_enable set issues a software reset
// R3: second_reset_flag set after second watchdog reset; software writes zero to clear
// R4: second timeout with second_irq_enable set raises the interrupt request
// R5: tick_scale_select picks divider 2^8 (codes 0-3), 2^12, 2^13, 2^14, 2^15
// R6: second_irq_flag set on second timeout; software writes zero to clear
// R7: second count reaching its 16-bit timeout gives interrupt or reset per enables
// R8: second timeout bytes written set timeout; reading them returns live count
// R9: second config resets to 0xA7; all registers except timed_access_lock itself are guarded by timed_access_lock
// R10: third watchdog always counts; nothing in software stops it
// R11: third watchdog counts at quarter rate using the same scale select
// R12: writing one to third_count_clear zeroes the third count; reads as zero
// R13: lowpower_halt_code is stored but code 101 no longer halts anything
// R14: third_reset_flag set after third watchdog reset; software writes zero to clear
// R15: third count reaching its timeout issues a reset; no interrupt path
// R16: third timeout bytes written set timeout; reading them returns live count
// R17: third config resets to 0xD1 and is guarded by timed_access_lock
// R18: second watchdog is a 16-bit counter clocked from slow_oscillator
// R19: after a timeout the counter restarts from zero
// R20: second counts once per prescaled tick; third divides that tick by four
module low_speed_dual_watchdog (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_CE,
  input  wire logic        I_SLOW_OSC,
  input  wire logic [31:0] I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  input  wire logic [31:0] I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  output logic             O_SECOND_IRQ,
  output logic             O_SOFT_RESET
);

  logic                 aw_got_ff;
  logic [31:0]          aw_addr_ff;
  logic                 w_got_ff;
  logic [7:0]           w_byte_ff;
  logic                 w_lane_ff;
  logic                 bvalid_ff;
  logic [1:0]           bresp_ff;
  logic                 rvalid_ff;
  logic [31:0]          rdata_ff;
  logic [1:0]           rresp_ff;
  wdog_pkg::second_cfg_t cfg2_ff;
  wdog_pkg::third_cfg_t  cfg3_ff;
  logic [15:0]          tout2_ff;
  logic [15:0]          tout3_ff;
  wdog_pkg::lock_state_t lock_ff;
  wdog_pkg::lock_state_t nxt_lock;
  logic [14:0]          pre_ff;
  logic [1:0]           qdiv_ff;
  logic                 osc_level;
  logic                 osc_prev_ff;
  logic                 soft_rst_ff;
  logic                 wr_fire;
  logic                 wr_prot;
  logic                 hit_w;
  logic                 hit_r;
  logic [7:0]           rd_byte;
  logic                 osc_edge;
  logic                 tick2;
  logic                 tick3;
  logic                 clr2;
  logic                 clr3;
  logic [15:0]          count2;
  logic [15:0]          count3;
  logic                 exp2;
  logic                 exp3;
  logic                 w_cfg2;
  logic                 w_cfg3;
  logic                 w_t2l;
  logic                 w_t2h;
  logic                 w_t3l;
  logic                 w_t3h;
  logic                 w_lock;

  // ---------------- slow oscillator and prescaler ----------------
  pin_sync3 u_osc_sync (
    .i_clk   (I_SYS_CLK),
    .i_rstn  (I_RSTN),
    .i_ce    (I_CE),
    .i_pin   (I_SLOW_OSC),
    .o_level (osc_level)
  );

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      osc_prev_ff <= 1'b0;
    end else if (I_CE) begin
      osc_prev_ff <= osc_level;
    end
  end

  assign osc_edge = osc_level && !osc_prev_ff;

  // R5 divider select
  assign tick2 = osc_edge &&
                 ((pre_ff & wdog_pkg::scale_mask(cfg2_ff.scale)) ==
                  wdog_pkg::scale_mask(cfg2_ff.scale));
  // R11 quarter-rate tick
  assign tick3 = tick2 && (qdiv_ff == wdog_pkg::THIRD_DIV_LAST);

  // R18 prescaler runs from slow_oscillator edges only
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pre_ff <= 15'h0000;
    end else if (I_CE && osc_edge) begin
      pre_ff <= pre_ff + 15'h0001;
    end
  end

  // R20 divide-by-four of the tick
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      qdiv_ff <= 2'h0;
    end else if (I_CE && tick2) begin
      qdiv_ff <= qdiv_ff + 2'h1;
    end
  end

  // ---------------- counters ----------------
  // R19 restart from zero inside the counter
  wd_counter u_second (
    .i_clk     (I_SYS_CLK),
    .i_rstn    (I_RSTN),
    .i_ce      (I_CE),
    .i_tick    (tick2),
    .i_clear   (clr2),
    .i_timeout (tout2_ff),
    .o_count   (count2),
    .o_expire  (exp2)
  );

  // R10 no enable: the third counter is never gated by software
  wd_counter u_third (
    .i_clk     (I_SYS_CLK),
    .i_rstn    (I_RSTN),
    .i_ce      (I_CE),
    .i_tick    (tick3),
    .i_clear   (clr3),
    .i_timeout (tout3_ff),
    .o_count   (count3),
    .o_expire  (exp3)
  );

  // ---------------- bus write path ----------------
  assign O_AWREADY = !aw_got_ff && !bvalid_ff;
  assign O_WREADY  = !w_got_ff && !bvalid_ff;
  assign O_BVALID  = bvalid_ff;
  assign O_BRESP   = bresp_ff;
  assign wr_fire   = aw_got_ff && w_got_ff && !bvalid_ff;

  assign w_cfg2 = wr_fire && (aw_addr_ff == wdog_pkg::A_SECOND_CFG);
  assign w_t2l  = wr_fire && (aw_addr_ff == wdog_pkg::A_SECOND_TL);
  assign w_t2h  = wr_fire && (aw_addr_ff == wdog_pkg::A_SECOND_TH);
  assign w_cfg3 = wr_fire && (aw_addr_ff == wdog_pkg::A_THIRD_CFG);
  assign w_t3l  = wr_fire && (aw_addr_ff == wdog_pkg::A_THIRD_TL);
  assign w_t3h  = wr_fire && (aw_addr_ff == wdog_pkg::A_THIRD_TH);
  assign w_lock = wr_fire && (aw_addr_ff == wdog_pkg::A_LOCK) && w_lane_ff;
  assign hit_w  = w_cfg2 || w_t2l || w_t2h || w_cfg3 || w_t3l || w_t3h ||
                  (wr_fire && (aw_addr_ff == wdog_pkg::A_LOCK));
  // R9 protected writes land only while the lock is open
  assign wr_prot = w_lane_ff && (lock_ff == wdog_pkg::LK_OPEN);

  // R1 self-clearing: a pulse, never stored
  assign clr2 = w_cfg2 && wr_prot && w_byte_ff[wdog_pkg::CLR_BIT];
  // R12 self-clearing third clear
  assign clr3 = w_cfg3 && wr_prot && w_byte_ff[wdog_pkg::CLR_BIT];

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      aw_got_ff  <= 1'b0;
      aw_addr_ff <= 32'h00000000;
    end else if (I_CE) begin
      if (I_AWVALID && O_AWREADY) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= I_AWADDR;
      end else if (wr_fire) begin
        aw_got_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      w_got_ff  <= 1'b0;
      w_byte_ff <= 8'h00;
      w_lane_ff <= 1'b0;
    end else if (I_CE) begin
      if (I_WVALID && O_WREADY) begin
        w_got_ff  <= 1'b1;
        w_byte_ff <= I_WDATA[7:0];
        w_lane_ff <= I_WSTRB[0];
      end else if (wr_fire) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= wdog_pkg::RESP_OKAY;
    end else if (I_CE) begin
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= hit_w ? wdog_pkg::RESP_OKAY : wdog_pkg::RESP_DECERR;
      end else if (I_BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ---------------- timed access lock ----------------
  // the lock closes after any one protected write, allowed or not
  always_comb begin
    nxt_lock = lock_ff;
    unique case (lock_ff)
      wdog_pkg::LK_LOCKED: begin
        if (w_lock && w_byte_ff == wdog_pkg::LOCK_KEY1) begin
          nxt_lock = wdog_pkg::LK_ARMED;
        end
      end
      wdog_pkg::LK_ARMED: begin
        if (wr_fire) begin
          nxt_lock = (w_lock && w_byte_ff == wdog_pkg::LOCK_KEY2) ?
                     wdog_pkg::LK_OPEN : wdog_pkg::LK_LOCKED;
        end
      end
      wdog_pkg::LK_OPEN: begin
        if (wr_fire && !w_lock) begin
          nxt_lock = wdog_pkg::LK_LOCKED;
        end
      end
      default: nxt_lock = wdog_pkg::LK_LOCKED;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      lock_ff <= wdog_pkg::LK_LOCKED;
    end else if (I_CE) begin
      lock_ff <= nxt_lock;
    end
  end

  // ---------------- configuration and timeouts ----------------
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cfg2_ff <= wdog_pkg::second_cfg_t'(wdog_pkg::RST_SECOND_CFG[6:0]);
    end else if (I_CE) begin
      if (w_cfg2 && wr_prot) begin
        cfg2_ff.reset_en   <= w_byte_ff[wdog_pkg::REN_BIT];
        cfg2_ff.irq_en     <= w_byte_ff[wdog_pkg::IEN_BIT];
        cfg2_ff.scale      <= w_byte_ff[3:1];
        cfg2_ff.reset_flag <= cfg2_ff.reset_flag & w_byte_ff[wdog_pkg::RF2_BIT];
        cfg2_ff.irq_flag   <= cfg2_ff.irq_flag & w_byte_ff[wdog_pkg::IF_BIT];
      end
      // R3 hardware set wins over a software clear
      if (exp2 && cfg2_ff.reset_en) begin
        cfg2_ff.reset_flag <= 1'b1;
      end
      // R6 flag set on every second timeout
      if (exp2) begin
        cfg2_ff.irq_flag <= 1'b1;
      end
    end
  end

  // R13 halt code stored only; it has no effect on counting
  // R17 third config reset value
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cfg3_ff <= {wdog_pkg::RST_THIRD_CFG[6:4], wdog_pkg::RST_THIRD_CFG[0]};
    end else if (I_CE) begin
      if (w_cfg3 && wr_prot) begin
        cfg3_ff.halt_code  <= w_byte_ff[6:4];
        cfg3_ff.reset_flag <= cfg3_ff.reset_flag & w_byte_ff[wdog_pkg::RF3_BIT];
      end
      // R14 set wins over clear
      if (exp3) begin
        cfg3_ff.reset_flag <= 1'b1;
      end
    end
  end

  // R8 R16 writes set the timeout, reads see the live count
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tout2_ff <= wdog_pkg::RST_TIMEOUT;
      tout3_ff <= wdog_pkg::RST_TIMEOUT;
    end else if (I_CE && wr_prot) begin
      if (w_t2l) tout2_ff[7:0]  <= w_byte_ff;
      if (w_t2h) tout2_ff[15:8] <= w_byte_ff;
      if (w_t3l) tout3_ff[7:0]  <= w_byte_ff;
      if (w_t3h) tout3_ff[15:8] <= w_byte_ff;
    end
  end

  // ---------------- reset and interrupt outputs ----------------
  // R2 R15 one-cycle software reset request
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      soft_rst_ff <= 1'b0;
    end else if (I_CE) begin
      soft_rst_ff <= (exp2 && cfg2_ff.reset_en) || exp3;
    end
  end

  assign O_SOFT_RESET = soft_rst_ff;
  // R4 R7 interrupt gated by its enable
  assign O_SECOND_IRQ = cfg2_ff.irq_flag && cfg2_ff.irq_en;

  // ---------------- bus read path ----------------
  assign O_ARREADY = !rvalid_ff;
  assign O_RVALID  = rvalid_ff;
  assign O_RDATA   = rdata_ff;
  assign O_RRESP   = rresp_ff;

  always_comb begin
    hit_r   = 1'b1;
    rd_byte = 8'h00;
    unique case (I_ARADDR)
      wdog_pkg::A_SECOND_CFG: rd_byte = {1'b0, cfg2_ff};
      wdog_pkg::A_SECOND_TL:  rd_byte = count2[7:0];
      wdog_pkg::A_SECOND_TH:  rd_byte = count2[15:8];
      wdog_pkg::A_THIRD_CFG:  rd_byte = {1'b0, cfg3_ff.halt_code, 3'b000,
                                         cfg3_ff.reset_flag};
      wdog_pkg::A_THIRD_TL:   rd_byte = count3[7:0];
      wdog_pkg::A_THIRD_TH:   rd_byte = count3[15:8];
      wdog_pkg::A_LOCK:       rd_byte = {5'b00000, lock_ff};
      default:                hit_r   = 1'b0;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= wdog_pkg::RESP_OKAY;
    end else if (I_CE) begin
      if (I_ARVALID && O_ARREADY) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= {24'h000000, rd_byte};
        rresp_ff  <= hit_r ? wdog_pkg::RESP_OKAY : wdog_pkg::RESP_DECERR;
      end else if (I_RREADY) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);

  property p_second_clear;
    clr2 && I_CE |=> count2 == 16'h0000;
  endproperty
  a_second_clear: assert property (p_second_clear) // R1
    else $error("second count not zero after clear");

  property p_second_reset;
    exp2 && cfg2_ff.reset_en && I_CE |=> O_SOFT_RESET ##1 (!O_SOFT_RESET || !$past(I_CE));
  endproperty
  a_second_reset: assert property (p_second_reset) // R2
    else $error("second timeout did not request reset");

  property p_second_rflag;
    exp2 && cfg2_ff.reset_en && I_CE |=> cfg2_ff.reset_flag;
  endproperty
  a_second_rflag: assert property (p_second_rflag) // R3
    else $error("second reset flag not set");

  property p_irq;
    exp2 && I_CE && cfg2_ff.irq_en && !(w_cfg2 && wr_prot) |=> O_SECOND_IRQ;
  endproperty
  a_irq: assert property (p_irq) // R4
    else $error("interrupt not raised on second timeout");

  property p_scale;
    tick2 |-> (pre_ff[7:0] == 8'hFF) && (cfg2_ff.scale < 3'h4 || pre_ff[11:8] == 4'hF);
  endproperty
  a_scale: assert property (p_scale) // R5
    else $error("tick off the divider boundary");

  property p_expire_at_timeout;
    exp2 |-> count2 == tout2_ff && tick2;
  endproperty
  a_expire_at_timeout: assert property (p_expire_at_timeout) // R7
    else $error("second expiry away from timeout");

  property p_third_counts;
    tick3 && I_CE && !clr3 && !exp3 |=> count3 == $past(count3) + 16'h0001;
  endproperty
  a_third_counts: assert property (p_third_counts) // R10
    else $error("third counter failed to advance");

  property p_quarter;
    tick3 |-> tick2 && qdiv_ff == 2'h3;
  endproperty
  a_quarter: assert property (p_quarter) // R11
    else $error("third tick not on every fourth tick");

  property p_third_clear;
    clr3 && I_CE |=> count3 == 16'h0000;
  endproperty
  a_third_clear: assert property (p_third_clear) // R12
    else $error("third count not zero after clear");

  property p_third_reset;
    exp3 && I_CE |=> O_SOFT_RESET && cfg3_ff.reset_flag;
  endproperty
  a_third_reset: assert property (p_third_reset) // R15
    else $error("third timeout did not reset");

  property p_restart;
    exp2 && I_CE |=> count2 == 16'h0000;
  endproperty
  a_restart: assert property (p_restart) // R19
    else $error("second counter did not restart");

  c_second_expire: cover property (exp2 && cfg2_ff.irq_en);
  c_third_expire:  cover property (exp3);
  c_unlocked_wr:   cover property (w_cfg2 && wr_prot);

endmodule : low_speed_dual_watchdog

/* File: low_speed_dual_watchdog_bench.sv */
`timescale 1ns/1ps
module low_speed_dual_watchdog_bench;
  logic        I_SYS_CLK, I_RSTN, I_CE, I_AWVALID, I_WVALID, I_BREADY;
  logic        I_SLOW_OSC = 1'b0;
  logic        I_ARVALID, I_RREADY, O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic        O_SECOND_IRQ, O_SOFT_RESET, osc_on, seen;
  logic [31:0] I_AWADDR, I_WDATA, I_ARADDR, O_RDATA, rd_val;
  logic [3:0]  I_WSTRB;
  logic [1:0]  O_BRESP, O_RRESP, rsp;
  logic [2:0]  osc_div = 3'h0;
  int          num_errors, cmp_count, hit;
  int          osc_edges = 0;

  low_speed_dual_watchdog i_dut (
    .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_CE(I_CE), .I_SLOW_OSC(I_SLOW_OSC),
    .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
    .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
    .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
    .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
    .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
    .O_SECOND_IRQ(O_SECOND_IRQ), .O_SOFT_RESET(O_SOFT_RESET)
  );

  initial begin
    I_SYS_CLK = 1'b0;
    forever #4 I_SYS_CLK = ~I_SYS_CLK;
  end

  // slow oscillator: period of eight system clocks, stands still while osc_on is low
  always @(posedge I_SYS_CLK) begin
    if (osc_on) begin
      osc_div    <= osc_div + 3'h1;
      I_SLOW_OSC <= osc_div[2];
      if (osc_div == 3'h4) osc_edges <= osc_edges + 1;
    end
  end

  task finish_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task stuck;
    chk(32'h0, 32'h1);
    finish_test;
  endtask : stuck

  task wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge I_SYS_CLK);
    I_AWADDR  <= a;
    I_WDATA   <= {24'h000000, d};
    I_AWVALID <= 1'b1;
    I_WVALID  <= 1'b1;
    I_BREADY  <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge I_SYS_CLK);
      if (I_AWVALID && O_AWREADY) I_AWVALID <= 1'b0;
      if (I_WVALID && O_WREADY) I_WVALID <= 1'b0;
      if (O_BVALID) begin
        rsp = O_BRESP;
        I_BREADY <= 1'b0;
        return;
      end
    end
    stuck;
  endtask : wr

  task rd(input logic [31:0] a);
    @(posedge I_SYS_CLK);
    I_ARADDR  <= a;
    I_ARVALID <= 1'b1;
    I_RREADY  <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge I_SYS_CLK);
      if (I_ARVALID && O_ARREADY) I_ARVALID <= 1'b0;
      if (O_RVALID) begin
        rd_val = O_RDATA;
        rsp = O_RRESP;
        I_RREADY <= 1'b0;
        return;
      end
    end
    stuck;
  endtask : rd

  // every watchdog register except the lock itself needs the lock opened just before the write
  task pw(input logic [31:0] a, input logic [7:0] d);
    wr(wdog_pkg::A_LOCK, wdog_pkg::LOCK_KEY1);
    wr(wdog_pkg::A_LOCK, wdog_pkg::LOCK_KEY2);
    wr(a, d);
  endtask : pw

  task run_edges(input int n);
    int stop;
    stop = osc_edges + n;
    osc_on <= 1'b1;
    for (int i = 0; i < n * 9 && osc_edges < stop; i++) @(posedge I_SYS_CLK);
    osc_on <= 1'b0;
    if (osc_edges < stop) stuck;
  endtask : run_edges

  task wait_event(input int bound);
    seen = 1'b0;
    hit = -1;
    @(posedge I_SYS_CLK);
    osc_on <= 1'b1;
    for (int i = 0; i < bound && hit < 0; i++) begin
      @(negedge I_SYS_CLK);
      seen = seen | O_SOFT_RESET;
      if (O_SECOND_IRQ || O_SOFT_RESET) hit = osc_edges;
    end
    repeat (8) begin
      @(negedge I_SYS_CLK);
      seen = seen | O_SOFT_RESET;
    end
    @(posedge I_SYS_CLK);
    osc_on <= 1'b0;
    if (hit < 0) stuck;
  endtask : wait_event

  task test_reset;
    chk({31'h0, O_SECOND_IRQ}, 32'h0);
    rd(wdog_pkg::A_SECOND_CFG);
    chk(rd_val, 32'h27);
    rd(wdog_pkg::A_THIRD_CFG);
    chk(rd_val, 32'h51);
    // locked write to the third config must neither clear its flag nor store the code
    wr(wdog_pkg::A_THIRD_CFG, 8'h80);
    rd(wdog_pkg::A_THIRD_CFG);
    chk(rd_val, 32'h51);
    rd(wdog_pkg::A_SECOND_TL);
    chk(rd_val, 32'h0);
    rd(wdog_pkg::A_LOCK + 32'h4);
    chk({rd_val[31:2], rsp}, {30'h0, wdog_pkg::RESP_DECERR});
    // a write while locked must leave the register untouched
    wr(wdog_pkg::A_SECOND_CFG, 8'h50);
    rd(wdog_pkg::A_SECOND_CFG);
    chk(rd_val, 32'h27);
    $display("test reset values done");
  endtask : test_reset

  task test_second_expiry;
    pw(wdog_pkg::A_SECOND_TL, 8'h02);
    pw(wdog_pkg::A_SECOND_TH, 8'h00);
    pw(wdog_pkg::A_SECOND_CFG, 8'h56);
    rd(wdog_pkg::A_SECOND_CFG);
    chk(rd_val, 32'h56);
    // three ticks of 256 oscillator edges each, counted from a fresh prescaler
    wait_event(8000);
    chk({31'h0, hit inside {768, 769}}, 32'h1);
    chk({31'h0, O_SECOND_IRQ}, 32'h1);
    chk({31'h0, seen}, 32'h1);
    rd(wdog_pkg::A_SECOND_CFG);
    chk(rd_val, 32'h77);
    rd(wdog_pkg::A_SECOND_TL);
    chk(rd_val, 32'h0);
    pw(wdog_pkg::A_SECOND_CFG, 8'h56);
    chk({31'h0, O_SECOND_IRQ}, 32'h0);
    $display("test second expiry done");
  endtask : test_second_expiry

  task test_clear_scale;
    run_edges(300);
    rd(wdog_pkg::A_SECOND_TL);
    chk(rd_val, 32'h1);
    rd(wdog_pkg::A_THIRD_TL);
    chk(rd_val, 32'h1);
    pw(wdog_pkg::A_SECOND_CFG, 8'h88);
    rd(wdog_pkg::A_SECOND_TL);
    chk(rd_val, 32'h0);
    rd(wdog_pkg::A_SECOND_CFG);
    chk(rd_val, 32'h08);
    // code 100 divides by 2^12, so 300 edges give no tick
    run_edges(300);
    rd(wdog_pkg::A_SECOND_TL);
    chk(rd_val, 32'h0);
    $display("test clear and scale done");
  endtask : test_clear_scale

  task test_third;
    pw(wdog_pkg::A_THIRD_TL, 8'h00);
    pw(wdog_pkg::A_THIRD_TH, 8'h00);
    pw(wdog_pkg::A_SECOND_CFG, 8'h00);
    pw(wdog_pkg::A_THIRD_CFG, 8'hD0);
    rd(wdog_pkg::A_THIRD_CFG);
    chk(rd_val, 32'h50);
    rd(wdog_pkg::A_THIRD_TL);
    chk(rd_val, 32'h0);
    wait_event(12000);
    chk({31'h0, seen}, 32'h1);
    chk({31'h0, O_SECOND_IRQ}, 32'h0);
    rd(wdog_pkg::A_THIRD_CFG);
    chk(rd_val, 32'h51);
    rd(wdog_pkg::A_THIRD_TL);
    chk(rd_val, 32'h0);
    $display("test third watchdog done");
  endtask : test_third

  initial begin
    num_errors = 0;
    cmp_count  = 0;
    osc_on     = 1'b0;
    I_RSTN     = 1'b0;
    I_CE       = 1'b1;
    I_AWADDR   = 32'h0;
    I_WDATA    = 32'h0;
    I_ARADDR   = 32'h0;
    I_WSTRB    = 4'hF;
    {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 5'h00;
    repeat (20) @(posedge I_SYS_CLK);
    I_RSTN <= 1'b1;
    test_reset;
    test_second_expiry;
    test_clear_scale;
    test_third;
    finish_test;
  end

  initial begin
    repeat (100000) @(posedge I_SYS_CLK);
    stuck;
  end
endmodule : low_speed_dual_watchdog_bench
